// *** sar_conv_pkg.sv ***
package sar_conv_pkg;

   // ---------------------------------------------------------------
   // Sizes and timing
   // ---------------------------------------------------------------
   localparam int          RES_BITS       = 16;
   localparam int          IDX_W          = 4;
   localparam int          CLK_PERIOD_NS  = 100;
   // Longest gap between conversions in the fast modes, in microseconds
   localparam int          IDLE_LIMIT_US  = 1000;
   localparam int          IDLE_LIMIT_CYC = (IDLE_LIMIT_US * 1000) / CLK_PERIOD_NS;
   localparam int          IDLE_W         = 16;
   localparam int          CAL_W          = 8;
   localparam int          FIFO_DEPTH     = 16;

   localparam logic [IDX_W-1:0]    MSB_IDX   = 4'hf;
   localparam logic [IDX_W-1:0]    LSB_IDX   = 4'h0;
   localparam logic [RES_BITS-1:0] CODE_ZERO = 16'h0000;
   localparam logic [RES_BITS-1:0] MSB_MASK  = 16'h8000;
   localparam logic [CAL_W-1:0]    CAL_CYC   = 8'h20;
   localparam logic [CAL_W-1:0]    CAL_ZERO  = 8'h00;
   localparam logic [IDLE_W-1:0]   IDLE_ZERO = 16'h0000;

   // ---------------------------------------------------------------
   // Mode select: {fast_sel, alt_sel}
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL    = 2'h0,
      MODE_LOW_POWER = 2'h1,
      MODE_FAST      = 2'h2,
      MODE_WIDEBAND  = 2'h3
   } conv_mode_t;

   // ---------------------------------------------------------------
   // Sequencer states, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_HOLD = 5'h02,
      ST_CONV = 5'h04,
      ST_DONE = 5'h08,
      ST_CAL  = 5'h10
   } conv_state_t;

   // Result word as it travels through the output buffer
   typedef struct packed {
      logic                stale;
      logic [RES_BITS-1:0] code;
   } result_word_t;

   localparam int RESULT_W = $bits(result_word_t);

endpackage

// *** sar_conversion_mode_control.sv ***
// Notes on behaviour
// - Conversion starts when conversion_start_n falls, once acquisition is over.
// - Sample is held on the falling edge of conversion_start_n.
// - Sixteen binary-weighted trials, most significant bit first.
// - After the last trial the code is formed, then busy drops.
// - Each result belongs to its own conversion, no pipeline delay.
// - Mode pins: 11 wideband fast, 10 fast, 00 normal, 01 low-power.
// - Fast modes reach 3 MSPS; accuracy needs gaps of at most 1 ms.
// - Normal mode reaches 2 MSPS with no limit on the gap.
// - Low-power mode powers circuits down after each conversion.
// - Reset high aborts; its falling edge starts calibration shown by busy.
// - Power-down finishes the current conversion, then inhibits new ones.
// - Output coding select picks straight binary or two's complement.
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// Result buffer
// ------------------------------------------------------------------
module result_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_r;
   logic [AW:0]      wr_nxt;
   logic [AW:0]      rd_r;
   logic [AW:0]      rd_nxt;
   logic             push;
   logic             pop;
   logic             full;
   logic             empty;

   // Pointers carry one extra bit so full and empty stay distinct
   always_comb begin
      full      = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
      empty     = (wr_r == rd_r);
      in_ready  = !full;
      out_valid = !empty;
      push      = in_valid && !full;
      pop       = out_ready && !empty;
      wr_nxt    = push ? wr_r + 1'b1 : wr_r;
      rd_nxt    = pop ? rd_r + 1'b1 : rd_r;
      out_data  = mem_r[rd_r[AW-1:0]];
   end

   // Storage has no reset; only the pointers define contents
   always_ff @(posedge clk_sys) begin
      if (clk_en && push) begin
         mem_r[wr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wr_r <= '0;
         rd_r <= '0;
      end else if (clk_en) begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
   end
endmodule

// ------------------------------------------------------------------
// Conversion sequencer and mode control
// ------------------------------------------------------------------
module sar_conversion_mode_control #(
   parameter int IDLE_LIMIT = sar_conv_pkg::IDLE_LIMIT_CYC,
   parameter int DEPTH      = sar_conv_pkg::FIFO_DEPTH
) (
   input  wire logic                          clk_sys,
   input  wire logic                          reset_n,
   input  wire logic                          clk_en,
   input  wire logic                          conversion_start_n,
   input  wire logic                          converter_reset,
   input  wire logic                          power_down_input,
   input  wire logic                          output_coding_select,
   input  wire logic                          mode_fast_sel,
   input  wire logic                          mode_alt_sel,
   input  wire logic                          comparator_keep,
   output logic                               busy,
   output logic                               sample_hold,
   output logic [sar_conv_pkg::RES_BITS-1:0]  trial_code,
   output logic                               analog_power_down,
   output logic [sar_conv_pkg::RES_BITS-1:0]  result_code,
   output logic                               result_valid,
   input  wire logic                          result_ready,
   output sar_conv_pkg::result_word_t         result_data
);
   import sar_conv_pkg::*;

   conv_state_t          state_r;
   conv_state_t          state_nxt;
   logic [IDX_W-1:0]     idx_r;
   logic [IDX_W-1:0]     idx_nxt;
   logic [RES_BITS-1:0]  trial_r;
   logic [RES_BITS-1:0]  trial_nxt;
   logic [RES_BITS-1:0]  code_r;
   logic [RES_BITS-1:0]  code_nxt;
   logic [CAL_W-1:0]     cal_r;
   logic [CAL_W-1:0]     cal_nxt;
   logic [IDLE_W-1:0]    idle_r;
   logic [IDLE_W-1:0]    idle_nxt;
   logic                 never_r;
   logic                 never_nxt;
   logic                 stale_r;
   logic                 stale_nxt;
   logic                 start_prev_r;
   logic                 rst_prev_r;
   logic                 hold_r;
   logic                 hold_nxt;
   logic                 start_fall;
   logic                 rst_fall;
   logic                 fast_mode;
   logic                 fifo_ready;
   logic                 push;
   logic [RES_BITS-1:0]  formed;
   logic [RES_BITS-1:0]  bit_mask;
   conv_mode_t           mode;
   result_word_t         word;

   // ---------------------------------------------------------------
   // Edge detection and mode decode
   // ---------------------------------------------------------------
   always_comb begin
      start_fall = start_prev_r && !conversion_start_n;
      rst_fall   = rst_prev_r && !converter_reset;
      mode       = conv_mode_t'({mode_fast_sel, mode_alt_sel});
      fast_mode  = (mode == MODE_FAST) || (mode == MODE_WIDEBAND);
      bit_mask   = MSB_MASK >> idx_r_inv(idx_r);
   end

   // Maps a bit index onto a shift from the MSB
   function automatic logic [IDX_W-1:0] idx_r_inv(input logic [IDX_W-1:0] i);
      idx_r_inv = MSB_IDX - i;
   endfunction

   // ---------------------------------------------------------------
   // Sequencer next state
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      idx_nxt   = idx_r;
      trial_nxt = trial_r;
      code_nxt  = code_r;
      cal_nxt   = cal_r;
      hold_nxt  = hold_r;
      stale_nxt = stale_r;
      push      = 1'b0;
      formed    = output_coding_select ? trial_r : (trial_r ^ MSB_MASK);
      unique case (state_r)
         ST_IDLE: begin
            // Power-down only blocks new starts, never one under way
            if (start_fall && !power_down_input) begin
               state_nxt = ST_HOLD;
               hold_nxt  = 1'b1;
               stale_nxt = fast_mode && (never_r || (idle_r >= IDLE_W'(IDLE_LIMIT)));
            end
         end
         ST_HOLD: begin
            // First trial: MSB set, all lower bits clear
            state_nxt = ST_CONV;
            idx_nxt   = MSB_IDX;
            trial_nxt = MSB_MASK;
         end
         ST_CONV: begin
            // Drop the trial bit if the comparator says it overshoots
            if (!comparator_keep) begin
               trial_nxt = trial_r & ~bit_mask;
            end else begin
               trial_nxt = trial_r;
            end
            if (idx_r == LSB_IDX) begin
               state_nxt = ST_DONE;
            end else begin
               idx_nxt   = idx_r - 1'b1;
               trial_nxt = trial_nxt | (bit_mask >> 1);
            end
         end
         ST_DONE: begin
            // A full buffer stalls here with busy still high
            if (fifo_ready) begin
               push      = 1'b1;
               code_nxt  = formed;
               hold_nxt  = 1'b0;
               state_nxt = ST_IDLE;
            end
         end
         ST_CAL: begin
            if (cal_r == CAL_ZERO) begin
               state_nxt = ST_IDLE;
            end else begin
               cal_nxt = cal_r - 1'b1;
            end
         end
      endcase
      // Reset input wins over everything in flight
      if (converter_reset) begin
         state_nxt = ST_IDLE;
         hold_nxt  = 1'b0;
         push      = 1'b0;
         code_nxt  = code_r;
         trial_nxt = CODE_ZERO;
      end else if (rst_fall) begin
         state_nxt = ST_CAL;
         cal_nxt   = CAL_CYC;
      end
   end

   // ---------------------------------------------------------------
   // Gap tracking for the fast modes
   // ---------------------------------------------------------------
   always_comb begin
      idle_nxt  = idle_r;
      never_nxt = never_r;
      // Saturate so a long gap never wraps back into the good range
      if (state_r == ST_HOLD) begin
         idle_nxt  = IDLE_ZERO;
         never_nxt = 1'b0;
      end else if (idle_r < IDLE_W'(IDLE_LIMIT)) begin
         idle_nxt = idle_r + 1'b1;
      end
      if (converter_reset) begin
         never_nxt = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_r      <= ST_IDLE;
         idx_r        <= MSB_IDX;
         trial_r      <= CODE_ZERO;
         code_r       <= CODE_ZERO;
         cal_r        <= CAL_ZERO;
         idle_r       <= IDLE_ZERO;
         never_r      <= 1'b1;
         stale_r      <= 1'b0;
         hold_r       <= 1'b0;
         start_prev_r <= 1'b1;
         rst_prev_r   <= 1'b0;
      end else if (clk_en) begin
         state_r      <= state_nxt;
         idx_r        <= idx_nxt;
         trial_r      <= trial_nxt;
         code_r       <= code_nxt;
         cal_r        <= cal_nxt;
         idle_r       <= idle_nxt;
         never_r      <= never_nxt;
         stale_r      <= stale_nxt;
         hold_r       <= hold_nxt;
         start_prev_r <= conversion_start_n;
         rst_prev_r   <= converter_reset;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      busy              = (state_r != ST_IDLE);
      sample_hold       = hold_r;
      trial_code        = trial_r;
      result_code       = code_r;
      // Low-power mode idles with circuits off between conversions
      analog_power_down = (state_r == ST_IDLE) &&
                          (power_down_input || (mode == MODE_LOW_POWER));
      word.stale        = stale_r;
      word.code         = formed;
   end

   result_fifo #(
      .WIDTH (RESULT_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (word),
      .out_valid (result_valid),
      .out_ready (result_ready),
      .out_data  (result_data)
   );

endmodule
`default_nettype wire

// *** sar_conversion_mode_control_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------
// Port-level checks of the conversion sequencer
// -----------------------------------------
module sar_conversion_mode_control_checker (
   input wire logic                              clk_sys,
   input wire logic                              reset_n,
   input wire logic                              conversion_start_n,
   input wire logic                              converter_reset,
   input wire logic                              power_down_input,
   input wire logic                              mode_fast_sel,
   input wire logic                              mode_alt_sel,
   input wire logic                              busy,
   input wire logic                              sample_hold,
   input wire logic [sar_conv_pkg::RES_BITS-1:0] trial_code,
   input wire logic                              analog_power_down,
   input wire logic [sar_conv_pkg::RES_BITS-1:0] result_code,
   input wire logic                              result_valid
);
   import sar_conv_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Start edge the sequencer is bound to take; busy also covers calibration
   sequence start_s;
      !busy && $fell(conversion_start_n) && !power_down_input && !converter_reset;
   endsequence
   // Normal end of a conversion, not an abort
   sequence finish_s;
      $fell(busy) && $past(sample_hold) && !$past(converter_reset);
   endsequence
   start_busy_a: assert property (start_s |=> busy [*8] ##10 busy)
      else $error("busy dropped before the trials ended");
   hold_start_a: assert property (start_s |=> sample_hold)
      else $error("sample not held after start");
   msb_first_a: assert property (start_s |-> ##2 trial_code == MSB_MASK)
      else $error("first trial is not the top bit");
   done_push_a: assert property (finish_s |-> result_valid)
      else $error("busy fell without a result");
   code_move_a: assert property (!$stable(result_code) |-> $fell(busy))
      else $error("result changed outside completion");
   abort_hold_a: assert property (converter_reset |=> !sample_hold)
      else $error("reset did not abort");
   cal_busy_a: assert property ($fell(converter_reset) |=> busy [*8] ##24 busy)
      else $error("calibration busy too short");
   pd_block_a: assert property (power_down_input && !busy && $fell(conversion_start_n) |=> !busy)
      else $error("start taken in power-down");
   lp_off_a: assert property (!busy && mode_alt_sel && !mode_fast_sel |-> analog_power_down)
      else $error("low-power idle not powered down");
   busy_on_a: assert property (busy |-> !analog_power_down)
      else $error("powered down while converting");
endmodule
`default_nettype wire

// *** host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------
// Host side: start strobe, comparator, sink
// -----------------------------------------
module host_model (
   input  wire logic        clk_sys,
   input  wire logic        busy,
   input  wire logic [15:0] trial_code,
   input  wire logic [15:0] vin,
   input  wire logic        stall,
   output logic             conversion_start_n,
   output logic             comparator_keep,
   output logic             result_ready
);
   // Ideal comparator: keep a trial bit while the trial stays at or below the input
   assign comparator_keep = (trial_code <= vin);
   assign result_ready    = !stall;
   initial conversion_start_n = 1'b1;
   // One-cycle low strobe; waiting for busy keeps spacing within every mode's rate
   task automatic convert();
      int n;
      n = 0;
      @(posedge clk_sys) conversion_start_n <= 1'b0;
      @(posedge clk_sys) conversion_start_n <= 1'b1;
      do begin
         @(negedge clk_sys);
         n++;
      end while (busy && n < 40);
   endtask
endmodule
`default_nettype wire

// *** tb_sar_conversion_mode_control.sv ***
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------
// Self-checking bench
// -----------------------------------------
module tb_sar_conversion_mode_control;
   import sar_conv_pkg::*;
   logic         clk_sys, reset_n, conv_rst, pd, osel, fsel, asel, stall, en;
   logic [15:0]  vin;
   int           error_cnt, total_checks;
   wire logic    start_n, keep, rdy, busy, hold, valid, apd;
   wire logic [15:0] trial, code;
   result_word_t word;
   sar_conversion_mode_control #(.IDLE_LIMIT(50)) dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(en), .conversion_start_n(start_n),
      .converter_reset(conv_rst), .power_down_input(pd), .output_coding_select(osel),
      .mode_fast_sel(fsel), .mode_alt_sel(asel), .comparator_keep(keep), .busy(busy),
      .sample_hold(hold), .trial_code(trial), .analog_power_down(apd), .result_code(code),
      .result_valid(valid), .result_ready(rdy), .result_data(word));
   host_model host (
      .clk_sys(clk_sys), .busy(busy), .trial_code(trial), .vin(vin), .stall(stall),
      .conversion_start_n(start_n), .comparator_keep(keep), .result_ready(rdy));
   // 100 ns clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic conv(input logic [15:0] v);
      @(posedge clk_sys) vin <= v;
      host.convert();
   endtask
   // Every mode with both codings; result is this conversion's own
   task automatic t_modes();
      logic [15:0] v, e;
      for (int m = 0; m < 8; m++) begin
         v = 16'h8123 + 16'(m);
         e = m[0] ? v : v ^ MSB_MASK;
         @(posedge clk_sys) {fsel, asel, osel} <= m[2:0];
         conv(v);
         chk({valid, code}, {1'b1, e});
         chk({valid, word.code}, {1'b1, e});
         chk(17'(apd), 17'(m[2:1] == 2'h1));
      end
   endtask
   // Long gap in fast mode marks the next result for discard
   task automatic t_stale();
      // Normal mode has no gap limit, so a long wait never marks a result
      @(posedge clk_sys) {fsel, asel} <= 2'h0;
      repeat (60) @(posedge clk_sys);
      conv(16'h00f0);
      chk(17'({valid, word.stale}), 17'h2);
      @(posedge clk_sys) {fsel, asel} <= 2'h2;
      repeat (60) @(posedge clk_sys);
      conv(16'h00ff);
      chk(17'({valid, word.stale}), 17'h3);
      conv(16'h0f0f);
      chk(17'({valid, word.stale}), 17'h2);
   endtask
   // Fill the buffer while the sink stalls, then drain in order
   task automatic t_fifo();
      @(posedge clk_sys) stall <= 1'b1;
      for (int i = 0; i < 17; i++) conv(16'(i));
      chk(17'(busy), 17'h1);
      @(posedge clk_sys) stall <= 1'b0;
      for (int i = 0; i < 17; i++) begin
         @(negedge clk_sys);
         chk({valid, word.code}, {1'b1, 16'(i)});
      end
      @(negedge clk_sys);
      chk(17'(valid), 17'h0);
   endtask
   // Power-down refuses a start but lets a running one finish
   task automatic t_pd();
      @(posedge clk_sys) pd <= 1'b1;
      conv(16'h5555);
      chk(17'({busy, valid}), 17'h0);
      @(posedge clk_sys) pd <= 1'b0;
      fork
         conv(16'h5555);
         begin
            repeat (6) @(posedge clk_sys);
            pd <= 1'b1;
         end
      join
      chk({valid, code}, {1'b1, 16'h5555});
      @(posedge clk_sys) pd <= 1'b0;
   endtask
   // Clock enable low mid-conversion freezes it without losing the code
   task automatic t_freeze();
      fork
         conv(16'h1234);
         begin
            repeat (6) @(posedge clk_sys);
            en <= 1'b0;
            repeat (8) @(posedge clk_sys);
            en <= 1'b1;
         end
      join
      chk({valid, code}, {1'b1, 16'h1234});
   endtask
   // Reset aborts mid-conversion, its release starts calibration
   task automatic t_rst();
      fork
         conv(16'h0abc);
         begin
            repeat (6) @(posedge clk_sys);
            conv_rst <= 1'b1;
         end
      join
      chk(17'({hold, valid}), 17'h0);
      @(posedge clk_sys) conv_rst <= 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(17'(busy), 17'h1);
      repeat (40) @(negedge clk_sys);
      chk(17'({busy, valid}), 17'h0);
   endtask
   // Main sequence
   initial begin
      {reset_n, conv_rst, pd, osel, fsel, asel, stall} = 7'h00;
      vin = 16'h0000;
      en = 1'b1;
      error_cnt = 0;
      total_checks = 0;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      chk({busy, code}, 17'h0);
      t_modes();
      t_stale();
      t_fifo();
      t_pd();
      t_freeze();
      t_rst();
      report_and_stop();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #1000000;
      error_cnt++;
      report_and_stop();
   end
endmodule
bind sar_conversion_mode_control sar_conversion_mode_control_checker checker_i (
   .clk_sys(clk_sys), .reset_n(reset_n), .conversion_start_n(conversion_start_n),
   .converter_reset(converter_reset), .power_down_input(power_down_input),
   .mode_fast_sel(mode_fast_sel), .mode_alt_sel(mode_alt_sel), .busy(busy),
   .sample_hold(sample_hold), .trial_code(trial_code), .analog_power_down(analog_power_down),
   .result_code(result_code), .result_valid(result_valid));
`default_nettype wire
